// file: core/rsc_pkg.sv
// constants and types for the reset source controller
package rsc_pkg;
  // ---------------------------------------------------------------
  // clocks and timing
  // ---------------------------------------------------------------
  localparam int REF_CLK_MHZ = 40;
  localparam int INPUT_CLK_MHZ = 40; // input clock is ref_clk
  localparam int BUS_CLK_MHZ = 40; // bus clock is ref_clk
  localparam int POR_REL_PERIODS = 1024; // input clock periods
  localparam int HARD_DLL_PERIODS = 3585; // bus clock periods
  localparam int HARD_NODLL_PERIODS = 512;
  localparam int SOFT_DLL_PERIODS = 3588;
  localparam int SOFT_NODLL_PERIODS = 515;
  localparam logic [11:0] POR_REL_CYC = 12'(POR_REL_PERIODS * REF_CLK_MHZ / INPUT_CLK_MHZ);
  localparam logic [11:0] HARD_DLL_CYC = 12'(HARD_DLL_PERIODS * REF_CLK_MHZ / BUS_CLK_MHZ);
  localparam logic [11:0] HARD_NODLL_CYC = 12'(HARD_NODLL_PERIODS * REF_CLK_MHZ / BUS_CLK_MHZ);
  localparam logic [11:0] SOFT_DLL_CYC = 12'(SOFT_DLL_PERIODS * REF_CLK_MHZ / BUS_CLK_MHZ);
  localparam logic [11:0] SOFT_NODLL_CYC = 12'(SOFT_NODLL_PERIODS * REF_CLK_MHZ / BUS_CLK_MHZ);
  localparam logic [1:0] SETTLE_CYC = 2'h3; // line echo through synchroniser
  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] CONTROL_OFS = 8'h08;
  localparam int CTL_HARD_BIT = 0;
  localparam int CTL_SOFT_BIT = 1;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic dll_disabled;
    logic [1:0] boot_mode;
    logic host_port_en;
    logic debug_entry;
    logic config_role;
  } rsc_cfg_t;
  localparam rsc_cfg_t CFG_RESET = 6'h00;
  typedef struct packed {
    logic soft_sw;
    logic hard_sw;
    logic soft_ext;
    logic hard_ext;
    logic por;
  } rsc_cause_t;
  localparam rsc_cause_t CAUSE_RESET = 5'h01;
  typedef enum logic [2:0] {
    ST_POR_HOLD, ST_POR_WAIT, ST_PLL_WAIT, ST_HARD, ST_SOFT, ST_RUN
  } rsc_state_t;
  // hard release count for the clock mode
  function automatic logic [11:0] hard_cyc(input logic dll_dis);
    return dll_dis ? HARD_NODLL_CYC : HARD_DLL_CYC;
  endfunction
  // soft release count for the clock mode
  function automatic logic [11:0] soft_cyc(input logic dll_dis);
    return dll_dis ? SOFT_NODLL_CYC : SOFT_DLL_CYC;
  endfunction
endpackage

// file: core/rsc_reset_source_controller.sv
// reset source controller: sequencing, straps, open-drain lines, cause
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_source_controller
  import rsc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // reset inputs and pll
  input wire logic power_on_reset_in_n,
  input wire logic system_pll_lock,
  // straps
  input wire logic config_role_strap,
  input wire logic debug_entry_strap,
  input wire logic host_port_strap,
  input wire logic [1:0] boot_mode_strap,
  input wire logic dll_disable_strap,
  // open-drain hard reset line
  input wire logic hard_reset_line_n,
  output logic hard_reset_line_n_drv,
  output logic hard_reset_line_oe,
  // open-drain soft reset line
  input wire logic soft_reset_line_n,
  output logic soft_reset_line_n_drv,
  output logic soft_reset_line_oe,
  // internal resets and configuration
  output logic internal_por,
  output rsc_cfg_t cfg,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rsc_state_t state_reg, state_next;
  logic [11:0] cnt_reg, cnt_next;
  logic [1:0] settle_reg;
  logic hard_s1_reg, hard_s2_reg, soft_s1_reg, soft_s2_reg;
  rsc_cause_t cause_reg;
  logic sw_hard, sw_soft, ext_hard, ext_soft, hard_req, soft_req;
  logic in_run;

  // ---------------------------------------------------------------
  // synchronisers for the external lines
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hard_s1_reg <= 1'b1;
      hard_s2_reg <= 1'b1;
      soft_s1_reg <= 1'b1;
      soft_s2_reg <= 1'b1;
    end else begin
      hard_s1_reg <= hard_reset_line_n;
      hard_s2_reg <= hard_s1_reg;
      soft_s1_reg <= soft_reset_line_n;
      soft_s2_reg <= soft_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  // line recognition only while running and own echo has settled; software requests only while running
  assign in_run = (state_reg == ST_RUN);
  assign sw_hard = reg_wr && (reg_addr == CONTROL_OFS) && reg_wdata[CTL_HARD_BIT];
  assign sw_soft = reg_wr && (reg_addr == CONTROL_OFS) && reg_wdata[CTL_SOFT_BIT];
  assign ext_hard = in_run && (settle_reg == 2'h0) && !hard_s2_reg;
  assign ext_soft = in_run && (settle_reg == 2'h0) && !soft_s2_reg;
  assign hard_req = ext_hard || (in_run && sw_hard);
  assign soft_req = ext_soft || (in_run && sw_soft);

  // ---------------------------------------------------------------
  // sequencer next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 12'h001;
    if (!power_on_reset_in_n) begin
      state_next = ST_POR_HOLD;
      cnt_next = 12'h000;
    end else begin
      case (state_reg)
        ST_POR_HOLD: begin
          state_next = ST_POR_WAIT;
          cnt_next = 12'h000;
        end
        ST_POR_WAIT: begin
          if (cnt_reg == POR_REL_CYC - 12'h001) begin
            state_next = ST_PLL_WAIT;
          end
        end
        ST_PLL_WAIT: begin
          cnt_next = 12'h000;
          if (system_pll_lock) begin
            state_next = ST_HARD;
          end
        end
        ST_HARD: begin
          if (cnt_reg == hard_cyc(cfg.dll_disabled) - 12'h001) begin
            state_next = ST_SOFT;
          end
        end
        ST_SOFT: begin
          if (cnt_reg == soft_cyc(cfg.dll_disabled) - 12'h001) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          cnt_next = 12'h000;
          if (hard_req) begin
            state_next = ST_HARD;
          end else if (soft_req) begin
            state_next = ST_SOFT;
            cnt_next = hard_cyc(cfg.dll_disabled);
          end
        end
        default: begin
          state_next = ST_POR_HOLD;
          cnt_next = 12'h000;
        end
      endcase
    end
  end

  // sequencer state and counter
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_POR_HOLD;
      cnt_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // echo guard; runs down only while both lines read high, so a pull left over from reset is ignored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      settle_reg <= SETTLE_CYC;
    end else if (state_next != ST_RUN) begin
      settle_reg <= SETTLE_CYC;
    end else if ((settle_reg != 2'h0) && hard_s2_reg && soft_s2_reg) begin
      settle_reg <= settle_reg - 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // reset outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      internal_por <= 1'b1;
      hard_reset_line_oe <= 1'b1;
      soft_reset_line_oe <= 1'b1;
      hard_reset_line_n_drv <= 1'b0;
      soft_reset_line_n_drv <= 1'b0;
    end else begin
      internal_por <= (state_next == ST_POR_HOLD) || (state_next == ST_POR_WAIT);
      hard_reset_line_oe <= (state_next != ST_SOFT) && (state_next != ST_RUN);
      soft_reset_line_oe <= (state_next != ST_RUN);
      hard_reset_line_n_drv <= 1'b0;
      soft_reset_line_n_drv <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // strap capture at por release
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg <= CFG_RESET;
    end else if ((state_reg == ST_POR_HOLD) && power_on_reset_in_n) begin
      cfg.config_role <= config_role_strap;
      cfg.debug_entry <= debug_entry_strap;
      cfg.host_port_en <= host_port_strap;
      cfg.boot_mode <= boot_mode_strap;
      cfg.dll_disabled <= dll_disable_strap;
    end
  end

  // ---------------------------------------------------------------
  // reset cause record
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_reg <= CAUSE_RESET;
    end else if (!power_on_reset_in_n && (state_reg != ST_POR_HOLD)) begin
      cause_reg <= CAUSE_RESET;
    end else if (power_on_reset_in_n && (hard_req || soft_req)) begin
      cause_reg <= '{soft_sw: sw_soft, hard_sw: sw_hard, soft_ext: ext_soft,
                     hard_ext: ext_hard, por: 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd && (reg_addr == STATUS_OFS)) begin
      reg_rdata <= {27'h0000000, cause_reg};
    end else if (reg_rd && (reg_addr == CONFIG_OFS)) begin
      reg_rdata <= {26'h0000000, cfg};
    end else begin
      reg_rdata <= 32'h0000_0000; // unmapped, control, idle
    end
  end

  // ---------------------------------------------------------------
  // assertion helpers
  // ---------------------------------------------------------------
  logic [11:0] rel_age_reg, lock_age_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rel_age_reg <= 12'h000;
      lock_age_reg <= 12'h000;
    end else begin
      rel_age_reg <= (state_reg == ST_POR_HOLD) ? 12'h000 : rel_age_reg + 12'h001;
      if (state_next == ST_HARD && state_reg != ST_HARD) begin
        lock_age_reg <= 12'h000;
      end else if (state_next == ST_SOFT && state_reg == ST_RUN) begin
        lock_age_reg <= hard_cyc(cfg.dll_disabled);
      end else begin
        lock_age_reg <= lock_age_reg + 12'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_por_all;
    @(posedge ref_clk) disable iff (rst)
    !power_on_reset_in_n |=> internal_por && hard_reset_line_oe && soft_reset_line_oe;
  endproperty
  a_por_all: assert property (p_por_all) else $error("por did not assert all resets");

  property p_role;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_POR_HOLD) && power_on_reset_in_n
      |=> cfg.config_role == $past(config_role_strap) ##1 $stable(cfg.config_role);
  endproperty
  a_role: assert property (p_role) else $error("role strap not captured");

  property p_debug;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_POR_HOLD) && power_on_reset_in_n |=> cfg.debug_entry == $past(debug_entry_strap);
  endproperty
  a_debug: assert property (p_debug) else $error("debug strap not captured");

  property p_host;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_POR_HOLD) && power_on_reset_in_n |=> cfg.host_port_en == $past(host_port_strap);
  endproperty
  a_host: assert property (p_host) else $error("host strap not captured");

  property p_boot;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_POR_HOLD) && power_on_reset_in_n |=> cfg.boot_mode == $past(boot_mode_strap);
  endproperty
  a_boot: assert property (p_boot) else $error("boot strap not captured");

  property p_cause_hold;
    @(posedge ref_clk) disable iff (rst)
    power_on_reset_in_n && !hard_req && !soft_req |=> $stable(cause_reg);
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("cause changed without event");

  property p_soft_only;
    @(posedge ref_clk) disable iff (rst)
    power_on_reset_in_n && soft_req && !hard_req |=> soft_reset_line_oe && !hard_reset_line_oe;
  endproperty
  a_soft_only: assert property (p_soft_only) else $error("soft reset drove hard line");

  property p_hard_ignored;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == ST_SOFT) && power_on_reset_in_n |=> state_reg inside {ST_SOFT, ST_RUN};
  endproperty
  a_hard_ignored: assert property (p_hard_ignored) else $error("hard seen during reset");

  property p_soft_ignored;
    @(posedge ref_clk) disable iff (rst)
    in_run && (settle_reg != 2'h0) && !sw_hard && !sw_soft && power_on_reset_in_n
      |=> state_reg == ST_RUN;
  endproperty
  a_soft_ignored: assert property (p_soft_ignored) else $error("echo taken as reset");

  property p_hard_soft;
    @(posedge ref_clk) disable iff (rst)
    hard_reset_line_oe |-> soft_reset_line_oe;
  endproperty
  a_hard_soft: assert property (p_hard_soft) else $error("hard without soft");

  property p_hard_od;
    @(posedge ref_clk) disable iff (rst)
    hard_reset_line_oe |-> hard_reset_line_n_drv == 1'b0;
  endproperty
  a_hard_od: assert property (p_hard_od) else $error("hard line driven high");

  property p_soft_od;
    @(posedge ref_clk) disable iff (rst)
    soft_reset_line_oe |-> soft_reset_line_n_drv == 1'b0;
  endproperty
  a_soft_od: assert property (p_soft_od) else $error("soft line driven high");

  property p_por_rel;
    @(posedge ref_clk) disable iff (rst)
    $fell(internal_por) |-> rel_age_reg == POR_REL_CYC;
  endproperty
  a_por_rel: assert property (p_por_rel) else $error("internal por release time wrong");

  property p_hard_rel;
    @(posedge ref_clk) disable iff (rst)
    $fell(hard_reset_line_oe) |-> lock_age_reg == hard_cyc(cfg.dll_disabled);
  endproperty
  a_hard_rel: assert property (p_hard_rel) else $error("hard release time wrong");

  property p_soft_rel;
    @(posedge ref_clk) disable iff (rst)
    $fell(soft_reset_line_oe) |-> lock_age_reg == soft_cyc(cfg.dll_disabled);
  endproperty
  a_soft_rel: assert property (p_soft_rel) else $error("soft release time wrong");

  property p_sync;
    @(posedge ref_clk) disable iff (rst)
    !$past(rst, 2) |-> hard_s2_reg == $past(hard_reset_line_n, 2)
      && soft_s2_reg == $past(soft_reset_line_n, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser depth wrong");

  // main scenarios
  c_por_done: cover property (@(posedge ref_clk) disable iff (rst)
    $fell(soft_reset_line_oe) && cause_reg.por);
  c_ext_hard: cover property (@(posedge ref_clk) disable iff (rst) ext_hard);
  c_ext_soft: cover property (@(posedge ref_clk) disable iff (rst) ext_soft && !ext_hard);
  c_sw_hard: cover property (@(posedge ref_clk) disable iff (rst) in_run && sw_hard);
endmodule
`default_nettype wire

// file: testbench/rsc_board_model.sv
// board reset supervisor and wired open-drain reset lines
`timescale 1ns/1ps
`default_nettype none
module rsc_board_model (
  // clock
  input wire logic ref_clk,
  // commands from the bench
  input wire logic por_req,
  input wire logic pull_hard,
  input wire logic pull_soft,
  // device drive enables
  input wire logic hard_oe,
  input wire logic soft_oe,
  // board side levels
  output logic power_on_reset_in_n,
  output wire logic hard_reset_line_n,
  output wire logic soft_reset_line_n
);
  logic [4:0] hold_cnt;
  // power-up starts with power-on reset held low
  initial begin
    power_on_reset_in_n = 1'b0;
    hold_cnt = 5'h00;
  end
  // hold power-on reset for at least sixteen clocks per request
  always @(posedge ref_clk) begin
    if (por_req || (!power_on_reset_in_n && hold_cnt != 5'h10)) begin
      power_on_reset_in_n <= 1'b0;
      hold_cnt <= (hold_cnt == 5'h10) ? hold_cnt : hold_cnt + 5'h01;
    end else begin
      power_on_reset_in_n <= 1'b1;
      hold_cnt <= 5'h00;
    end
  end
  // pull-ups; any party only ever pulls low
  assign hard_reset_line_n = (hard_oe || pull_hard) ? 1'b0 : 1'b1;
  assign soft_reset_line_n = (soft_oe || pull_soft) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the reset source controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %0h exp %0h", $time, (g), (e)); end end
module tb_top
  import rsc_pkg::*;
;
  logic ref_clk, rst, por_req, pull_hard, pull_soft, system_pll_lock;
  logic config_role_strap, debug_entry_strap, host_port_strap, dll_disable_strap;
  logic [1:0] boot_mode_strap;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, internal_por, hard_oe, soft_oe, hard_drv, soft_drv;
  wire logic por_n, hard_line_n, soft_line_n;
  rsc_cfg_t cfg;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // ---------------------------------------------------------------
  // clock, cycle count, timeout
  // ---------------------------------------------------------------
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ---------------------------------------------------------------
  // design and board
  // ---------------------------------------------------------------
  rsc_reset_source_controller u_dut (
    .ref_clk(ref_clk), .rst(rst), .power_on_reset_in_n(por_n),
    .system_pll_lock(system_pll_lock), .config_role_strap(config_role_strap),
    .debug_entry_strap(debug_entry_strap), .host_port_strap(host_port_strap),
    .boot_mode_strap(boot_mode_strap), .dll_disable_strap(dll_disable_strap),
    .hard_reset_line_n(hard_line_n), .hard_reset_line_n_drv(hard_drv),
    .hard_reset_line_oe(hard_oe), .soft_reset_line_n(soft_line_n),
    .soft_reset_line_n_drv(soft_drv), .soft_reset_line_oe(soft_oe),
    .internal_por(internal_por), .cfg(cfg), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  rsc_board_model u_board (
    .ref_clk(ref_clk), .por_req(por_req), .pull_hard(pull_hard), .pull_soft(pull_soft),
    .hard_oe(hard_oe), .soft_oe(soft_oe), .power_on_reset_in_n(por_n),
    .hard_reset_line_n(hard_line_n), .soft_reset_line_n(soft_line_n)
  );
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic sel(input int which);
    case (which)
      0: return internal_por;
      1: return hard_oe;
      2: return soft_oe;
      default: return por_n;
    endcase
  endfunction
  // cycle number of the first edge after which a level is seen
  task automatic wait_for(input int which, input logic v, output int t);
    for (int i = 0; i < 5000; i++) begin
      @(posedge ref_clk);
      #1;
      if (sel(which) === v) begin
        t = cyc;
        return;
      end
    end
    t = -1;
    `CHK(1'b0, 1'b1);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e);
  endtask
  // board pulls one line low for two cycles
  task automatic ext_pulse(input int which, output int t0);
    @(posedge ref_clk);
    if (which == 0) pull_hard <= 1'b1;
    else pull_soft <= 1'b1;
    #1 t0 = cyc;
    @(posedge ref_clk);
    @(posedge ref_clk);
    pull_hard <= 1'b0;
    pull_soft <= 1'b0;
  endtask
  // power-on release with straps s, then pll lock and line releases
  task automatic por_run(input logic [5:0] s, input int hc, input int sc);
    int t0, t1;
    @(posedge ref_clk);
    {dll_disable_strap, boot_mode_strap, host_port_strap, debug_entry_strap,
      config_role_strap} <= s;
    por_req <= 1'b0;
    wait_for(3, 1'b1, t0);
    @(posedge ref_clk);
    {dll_disable_strap, boot_mode_strap, host_port_strap, debug_entry_strap,
      config_role_strap} <= ~s;
    wait_for(0, 1'b0, t1);
    `CHK(t1 - t0, 1025);
    `CHK(cfg, s);
    @(posedge ref_clk);
    system_pll_lock <= 1'b1;
    #1 t0 = cyc;
    wait_for(1, 1'b0, t1);
    `CHK(t1 - t0, hc + 1);
    `CHK(soft_oe, 1'b1);
    wait_for(2, 1'b0, t1);
    `CHK(t1 - t0, sc + 1);
    rd_chk(STATUS_OFS, 32'h01);
    rd_chk(CONFIG_OFS, 32'(s));
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int t0, t1, t2;
    {rst, por_req, pull_hard, pull_soft, system_pll_lock} = 5'h18;
    {config_role_strap, debug_entry_strap, host_port_strap, dll_disable_strap} = 4'h0;
    boot_mode_strap = 2'h0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK({internal_por, hard_oe, soft_oe}, 3'h7);
    `CHK({hard_drv, soft_drv}, 2'h0);
    por_run(6'h2b, 512, 515);
    // external hard, with soft and hard pulled again meanwhile
    ext_pulse(0, t0);
    wait_for(1, 1'b1, t1);
    `CHK(t1 - t0, 3);
    `CHK(soft_oe, 1'b1);
    ext_pulse(1, t2);
    ext_pulse(0, t2);
    wait_for(1, 1'b0, t2);
    `CHK(t2 - t1, 512);
    wait_for(2, 1'b0, t2);
    `CHK(t2 - t1, 515);
    rd_chk(STATUS_OFS, 32'h02);
    rd_chk(STATUS_OFS, 32'h02);
    repeat (4) @(posedge ref_clk);
    // external soft alone
    ext_pulse(1, t0);
    wait_for(2, 1'b1, t1);
    `CHK(t1 - t0, 3);
    `CHK(hard_oe, 1'b0);
    wait_for(2, 1'b0, t2);
    `CHK(t2 - t1, 3);
    rd_chk(STATUS_OFS, 32'h04);
    repeat (4) @(posedge ref_clk);
    // software hard then software soft
    for (int i = 0; i < 2; i++) begin
      reg_write(CONTROL_OFS, 32'h1 << i);
      #1 t0 = cyc;
      wait_for(2, 1'b0, t1);
      `CHK(t1 - t0, (i == 0) ? 515 : 3);
      rd_chk(STATUS_OFS, (i == 0) ? 32'h08 : 32'h10);
      repeat (4) @(posedge ref_clk);
    end
    reg_write(STATUS_OFS, 32'h1f);
    rd_chk(STATUS_OFS, 32'h10);
    rd_chk(CONTROL_OFS, 32'h0);
    rd_chk(8'h0c, 32'h0);
    // power-on reset in mid-run, dll on this time
    @(posedge ref_clk);
    por_req <= 1'b1;
    system_pll_lock <= 1'b0;
    wait_for(3, 1'b0, t0);
    wait_for(0, 1'b1, t1);
    `CHK(t1 - t0, 1);
    `CHK({hard_oe, soft_oe}, 2'h3);
    por_run(6'h04, 3585, 3588);
    tally_and_finish();
  end
endmodule
`default_nettype wire
